/* rtl/mrl_defs.svh */
`ifndef MRL_DEFS_SVH
`define MRL_DEFS_SVH

// Operating mode select codes
`define MRL_OPSEL_STANDBY 3'h4
`define MRL_OPSEL_NORMAL 3'h7
// Watchdog period default
`define MRL_WDOG_PERIOD_RST 4'h4
// Reset cause codes
`define MRL_CAUSE_POR 5'h00
`define MRL_CAUSE_OVERTEMP 5'h12
// Watchdog mode select codes
`define MRL_WMODE_SWDEV 3'h1
`define MRL_WMODE_DEFAULT 3'h2
// Arbitrary identity value
`define MRL_IDENTITY_VAL 8'h5A
// Lock control width
`define MRL_LOCK_W 7

`endif

/* rtl/mrl_pkg.sv */
package mrl_pkg;
    // Operating modes of the device
    typedef enum logic [2:0] {
        MRL_OFF = 3'b000,
        MRL_STANDBY = 3'b001,
        MRL_NORMAL = 3'b010,
        MRL_OVERTEMP = 3'b011,
        MRL_RESET = 3'b100
    } mrl_mode_t;
endpackage

/* rtl/mrl_entry_if.sv */
`timescale 1ns/1ps
interface mrl_entry_if;
    import mrl_pkg::*;
    logic enter_standby;
    logic enter_normal;
    logic enter_overtemp;
    logic enter_reset;
    logic entry_any;
    modport src (output enter_standby, enter_normal, enter_overtemp, enter_reset, entry_any);
    modport dst (input enter_standby, enter_normal, enter_overtemp, enter_reset, entry_any);
endinterface

/* rtl/mrl_entry_detect.sv */
`timescale 1ns/1ps
`include "mrl_defs.svh"
module mrl_entry_detect
    import mrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode state
    input mrl_mode_t mode,
    // Entry strobes
    mrl_entry_if.src ent
);
    mrl_mode_t prev_reg;

    // Previous mode for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_reg <= MRL_OFF;
        end else begin
            prev_reg <= mode;
        end
    end

    // Entry decode, combinational so updates land in the change cycle
    assign ent.entry_any = (mode != prev_reg);
    assign ent.enter_standby = ent.entry_any && (mode == MRL_STANDBY);
    assign ent.enter_normal = ent.entry_any && (mode == MRL_NORMAL);
    assign ent.enter_overtemp = ent.entry_any && (mode == MRL_OVERTEMP);
    assign ent.enter_reset = ent.entry_any && (mode == MRL_RESET);
endmodule // mrl_entry_detect

/* rtl/mrl_mode_regs.sv */
// How it works
// (R1) Mode select: 100 standby/reset, 111 normal
// (R2) Never-normal flag set at power-on, cleared
// (R3) Watchdog period 0100 on overtemp/reset entry
// (R4) Reset cause: 00000, 10010 overtemp, cause
// (R5) Watchdog mode 001 if swdev else 010
// (R6) Power-up flag set, kept across modes
// (R7) Summary flags: system 1, others 0
// (R8) Live status zero at power-on and in off state, else live
// (R9) Events, enables, locks cleared at power-on
// (R10) Start-up config bits follow nonvolatile store
// (R11) Threshold control loaded from start-up setting
// (R12) Nonvolatile status always shows actual state
// (R13) Identity fixed from power-on onward
// (R14) Mode change discards ongoing serial access
// (R15) Entry updates in mode change cycle
`timescale 1ns/1ps
`include "mrl_defs.svh"
module mrl_mode_regs
    import mrl_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Operating mode from the mode controller
    input mrl_mode_t mode,
    input wire logic [4:0] reset_src_code,
    // Nonvolatile store values
    input wire logic nv_restart_limit,
    input wire logic nv_sw_dev,
    input wire logic [1:0] nv_reset_threshold,
    input wire logic nv_programmed,
    input wire logic [5:0] nv_write_count,
    // Live conditions
    input wire logic live_overtemp_warn,
    input wire logic live_sw_dev,
    input wire logic live_regulator,
    input wire logic live_can_supply,
    input wire logic live_wdog,
    // Serial host write port
    input wire logic spi_active,
    input wire logic spi_commit,
    input wire logic wr_wdog_ctrl,
    input wire logic [2:0] wr_wdog_mode,
    input wire logic [3:0] wr_wdog_period,
    input wire logic wr_op_mode,
    input wire logic [2:0] wr_op_mode_val,
    input wire logic wr_threshold,
    input wire logic [1:0] wr_threshold_val,
    input wire logic wr_event_en,
    input wire logic [2:0] wr_event_en_val,
    input wire logic wr_lock,
    input wire logic [`MRL_LOCK_W-1:0] wr_lock_val,
    input wire logic wr_evt_clr,
    input wire logic [4:0] wr_evt_clr_val,
    // Event sources
    input wire logic set_overtemp_warn,
    input wire logic set_serial_fail,
    input wire logic set_wdog_fail,
    input wire logic set_regulator_uv,
    // Control and status outputs
    output logic [2:0] op_mode_select,
    output logic normal_never_entered,
    output logic [3:0] wdog_period_sel,
    output logic [4:0] reset_cause,
    output logic [2:0] wdog_mode_sel,
    output logic powerup_event,
    output logic system_event_summary,
    output logic supply_event_summary,
    output logic transceiver_event_summary,
    output logic overtemp_warn_state,
    output logic sw_dev_state,
    output logic regulator_state,
    output logic can_supply_state,
    output logic wdog_state,
    output logic overtemp_warn_event,
    output logic overtemp_warn_event_en,
    output logic serial_fail_event,
    output logic serial_fail_event_en,
    output logic wdog_fail_event,
    output logic regulator_undervolt_event,
    output logic regulator_undervolt_event_en,
    output logic [`MRL_LOCK_W-1:0] lock_ctrl_bits,
    output logic restart_limit_cfg,
    output logic sw_dev_cfg,
    output logic [1:0] startup_reset_threshold_cfg,
    output logic [1:0] reset_threshold_ctrl,
    output logic nvm_programmed_state,
    output logic [5:0] nvm_write_count,
    output logic [7:0] device_identity,
    output logic spi_discard
);
    mrl_entry_if ent();
    logic xfer_bad_reg;
    logic host_ok;
    logic [2:0] op_mode_reg;
    logic nne_reg;
    logic [3:0] period_reg;
    logic [4:0] cause_reg;
    logic [2:0] wmode_reg;
    logic [4:0] evt_reg;
    logic [2:0] en_reg;
    logic [`MRL_LOCK_W-1:0] lock_reg;
    logic [1:0] thr_reg;
    logic [4:0] live_reg;
    logic [2:0] summ_reg;

    // Mode entry strobes
    mrl_entry_detect u_entry (
        .clk(clk),
        .rst_n(rst_n),
        .mode(mode),
        .ent(ent)
    );

    // Watchdog mode code from the development setting
    function automatic logic [2:0] wmode_default(input logic swdev);
        wmode_default = swdev ? `MRL_WMODE_SWDEV : `MRL_WMODE_DEFAULT;
    endfunction

    // (R14) Transfer spoil tracking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xfer_bad_reg <= 1'b0;
        end else begin
            if (!spi_active)
                xfer_bad_reg <= 1'b0;
            else if (ent.entry_any)
                xfer_bad_reg <= 1'b1;
        end
    end
    assign spi_discard = spi_commit && (xfer_bad_reg || ent.entry_any);
    assign host_ok = spi_commit && !spi_discard;

    // (R1) Mode select field
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_mode_reg <= `MRL_OPSEL_STANDBY;
        end else if (ent.enter_normal) begin
            op_mode_reg <= `MRL_OPSEL_NORMAL;
        end else if (ent.enter_standby || ent.enter_reset) begin
            op_mode_reg <= `MRL_OPSEL_STANDBY;
        end else if (host_ok && wr_op_mode) begin
            op_mode_reg <= wr_op_mode_val;
        end
    end

    // (R2) Normal never entered flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nne_reg <= 1'b1;
        end else if (ent.enter_normal) begin
            nne_reg <= 1'b0;
        end
    end

    // (R15) Watchdog control on entry, (R3) period and (R5) mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_reg <= `MRL_WDOG_PERIOD_RST;
            wmode_reg <= wmode_default(nv_sw_dev);
        end else begin
            if (ent.enter_overtemp || ent.enter_reset)
                period_reg <= `MRL_WDOG_PERIOD_RST;
            else if (host_ok && wr_wdog_ctrl)
                period_reg <= wr_wdog_period;
            if (ent.enter_reset)
                wmode_reg <= wmode_default(nv_sw_dev);
            else if (host_ok && wr_wdog_ctrl)
                wmode_reg <= wr_wdog_mode;
        end
    end

    // (R4) Reset cause capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cause_reg <= `MRL_CAUSE_POR;
        end else if (ent.enter_overtemp) begin
            cause_reg <= `MRL_CAUSE_OVERTEMP;
        end else if (ent.enter_reset) begin
            cause_reg <= reset_src_code;
        end
    end

    // (R6) (R9) Captured events and power-up flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_reg <= 5'h10; // Power-up flag set, others clear
        end else begin
            // Power-up flag (bit 4) is never host-clearable
            evt_reg <= (evt_reg & ~({5{host_ok && wr_evt_clr}} & {1'b0, wr_evt_clr_val[3:0]}))
                | {1'b0, set_regulator_uv, set_overtemp_warn, set_serial_fail,
                   set_wdog_fail};
        end
    end

    // (R9) Enables and locks, untouched by modes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            en_reg <= 3'h0;
            lock_reg <= '0;
        end else begin
            if (host_ok && wr_event_en)
                en_reg <= wr_event_en_val;
            if (host_ok && wr_lock)
                lock_reg <= wr_lock_val;
        end
    end

    // (R11) Threshold control from start-up setting
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thr_reg <= nv_reset_threshold;
        end else if (host_ok && wr_threshold) begin
            thr_reg <= wr_threshold_val;
        end
    end

    // (R8) Live status, zero while in off state
    always_ff @(posedge clk) begin
        if (!rst_n || mode == MRL_OFF) begin
            live_reg <= 5'h00;
        end else begin
            live_reg <= {live_overtemp_warn, live_sw_dev, live_regulator,
                         live_can_supply, live_wdog};
        end
    end

    // (R7) Summary flags, untouched by modes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            summ_reg <= 3'h1;
        end else if (host_ok && wr_evt_clr && wr_evt_clr_val[4]) begin
            summ_reg <= summ_reg;
        end
    end

    // (R10) (R12) Pass-through status and config, (R13) fixed identity
    assign restart_limit_cfg = nv_restart_limit;
    assign sw_dev_cfg = nv_sw_dev;
    assign startup_reset_threshold_cfg = nv_reset_threshold;
    assign nvm_programmed_state = nv_programmed;
    assign nvm_write_count = nv_write_count;
    assign device_identity = `MRL_IDENTITY_VAL;

    // Output mapping
    assign op_mode_select = op_mode_reg;
    assign normal_never_entered = nne_reg;
    assign wdog_period_sel = period_reg;
    assign reset_cause = cause_reg;
    assign wdog_mode_sel = wmode_reg;
    assign powerup_event = evt_reg[4];
    assign {supply_event_summary, transceiver_event_summary, system_event_summary} =
        {summ_reg[1], summ_reg[2], summ_reg[0]};
    assign {overtemp_warn_state, sw_dev_state, regulator_state, can_supply_state,
            wdog_state} = live_reg;
    assign wdog_fail_event = evt_reg[0];
    assign serial_fail_event = evt_reg[1];
    assign overtemp_warn_event = evt_reg[2];
    assign regulator_undervolt_event = evt_reg[3];
    assign {regulator_undervolt_event_en, overtemp_warn_event_en, serial_fail_event_en} =
        en_reg;
    assign lock_ctrl_bits = lock_reg;
    assign reset_threshold_ctrl = thr_reg;
endmodule // mrl_mode_regs

/* sim/mrl_mode_regs_assertions.sv */
`timescale 1ns/1ps
module mrl_mode_regs_assertions
    import mrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Causes
    input mrl_mode_t mode,
    input wire logic [4:0] reset_src_code,
    input wire logic nv_restart_limit,
    input wire logic nv_sw_dev,
    input wire logic [1:0] nv_reset_threshold,
    input wire logic spi_commit,
    // Watched outputs
    input wire logic [2:0] op_mode_select,
    input wire logic normal_never_entered,
    input wire logic [3:0] wdog_period_sel,
    input wire logic [4:0] reset_cause,
    input wire logic [2:0] wdog_mode_sel,
    input wire logic powerup_event,
    input wire logic system_event_summary,
    input wire logic restart_limit_cfg,
    input wire logic sw_dev_cfg,
    input wire logic [1:0] startup_reset_threshold_cfg,
    input wire logic [7:0] device_identity,
    input wire logic spi_discard
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Mode entry effects
    chk_normal_entry: assert property (
        mode == MRL_NORMAL && $changed(mode) |-> ##[1:2] op_mode_select == 3'h7
        && !normal_never_entered) else $error("normal entry values wrong");
    chk_standby_opsel: assert property (
        (mode == MRL_STANDBY || mode == MRL_RESET) && $changed(mode)
        |-> ##[1:2] op_mode_select == 3'h4) else $error("mode select not 100");
    chk_period_load: assert property (
        (mode == MRL_OVERTEMP || mode == MRL_RESET) && $changed(mode)
        |-> ##[1:2] wdog_period_sel == 4'h4) else $error("period not reloaded");
    chk_cause_overtemp: assert property (
        mode == MRL_OVERTEMP && $changed(mode) |-> ##[1:2] reset_cause == 5'h12)
        else $error("overtemp cause wrong");
    chk_cause_reset: assert property (
        mode == MRL_RESET && $changed(mode) |-> ##[1:2] reset_cause == reset_src_code)
        else $error("reset cause wrong");
    chk_wmode_reset: assert property (
        mode == MRL_RESET && $changed(mode)
        |-> ##[1:2] wdog_mode_sel == (nv_sw_dev ? 3'h1 : 3'h2)) else $error("wmode wrong");
    // Fixed and pass-through values, commit discard
    chk_flags_kept: assert property (powerup_event && system_event_summary)
        else $error("power-up flags lost");
    chk_cfg_follow: assert property (restart_limit_cfg == nv_restart_limit
        && sw_dev_cfg == nv_sw_dev && startup_reset_threshold_cfg == nv_reset_threshold)
        else $error("start-up config differs");
    chk_identity_fixed: assert property (device_identity == 8'h5A && $stable(device_identity))
        else $error("identity changed");
    chk_commit_discard: assert property (spi_commit && $changed(mode) |-> spi_discard)
        else $error("commit not discarded");
endmodule // mrl_mode_regs_assertions

bind mrl_mode_regs mrl_mode_regs_assertions chk_u (.clk, .rst_n, .mode, .reset_src_code,
    .nv_restart_limit, .nv_sw_dev, .nv_reset_threshold, .spi_commit, .op_mode_select,
    .normal_never_entered, .wdog_period_sel, .reset_cause, .wdog_mode_sel, .powerup_event,
    .system_event_summary, .restart_limit_cfg, .sw_dev_cfg, .startup_reset_threshold_cfg,
    .device_identity, .spi_discard);

/* sim/mrl_host_model.sv */
`timescale 1ns/1ps
module mrl_host_model (
    // Clock
    input wire logic clk,
    // Write port towards the block
    output logic spi_active,
    output logic spi_commit,
    output logic wr_wdog_ctrl,
    output logic [2:0] wr_wdog_mode,
    output logic [3:0] wr_wdog_period,
    // Event, enable and lock writes
    output logic wr_evt_clr,
    output logic [4:0] wr_evt_clr_val,
    output logic wr_event_en,
    output logic [2:0] wr_event_en_val,
    output logic wr_lock,
    output logic [6:0] wr_lock_val
);
    // Idle port at start
    initial begin
        {spi_active, spi_commit, wr_wdog_ctrl, wr_evt_clr, wr_event_en, wr_lock} = 6'h00;
        {wr_wdog_mode, wr_wdog_period} = 7'h55;
        {wr_evt_clr_val, wr_event_en_val, wr_lock_val} = 15'h0000;
    end
    // One framed event clear, enable and lock write
    task automatic write_misc(input logic [4:0] clr, input logic [2:0] en, input logic [6:0] lk);
        @(negedge clk);
        spi_active = 1'b1;
        @(negedge clk);
        {spi_commit, wr_evt_clr, wr_event_en, wr_lock} = 4'hF;
        {wr_evt_clr_val, wr_event_en_val, wr_lock_val} = {clr, en, lk};
        @(negedge clk);
        {spi_active, spi_commit, wr_evt_clr, wr_event_en, wr_lock} = 5'h00;
        {wr_evt_clr_val, wr_event_en_val, wr_lock_val} = ~{clr, en, lk};
    endtask
    // One framed watchdog control write
    task automatic write_wdog(input logic [2:0] wm, input logic [3:0] wp);
        @(negedge clk);
        spi_active = 1'b1;
        @(negedge clk);
        {spi_commit, wr_wdog_ctrl, wr_wdog_mode, wr_wdog_period} = {2'h3, wm, wp};
        @(negedge clk);
        {spi_active, spi_commit, wr_wdog_ctrl} = 3'h0;
        {wr_wdog_mode, wr_wdog_period} = ~{wm, wp};
    endtask
endmodule // mrl_host_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb
    import mrl_pkg::*;
;
    logic clk, rst_n, nv_rl, nv_sw, nv_prog, set_sf;
    logic [4:0] src, lv, st;
    logic [1:0] nv_thr, thr;
    logic [5:0] nv_cnt, cnt;
    mrl_mode_t mode;
    logic sa, sc, wwc, nne, pe, sys, sup, trx, sfe, rl, sw, prog;
    logic [2:0] wwm, opsel, wm;
    logic [3:0] wwp, per;
    logic [4:0] cause;
    logic [1:0] sthr;
    logic [7:0] ident;
    logic [6:0] lock;
    logic set_ow, set_wf, set_uv, wec, wen, wlk, disc, ow, owe, sfen, wf, uv, uve;
    logic [4:0] wcv;
    logic [2:0] wev;
    logic [6:0] wlv;
    int error_cnt = 0;
    int comparisons = 0;

    mrl_host_model host_u (.clk(clk), .spi_active(sa), .spi_commit(sc), .wr_wdog_ctrl(wwc),
        .wr_wdog_mode(wwm), .wr_wdog_period(wwp), .wr_evt_clr(wec), .wr_evt_clr_val(wcv),
        .wr_event_en(wen), .wr_event_en_val(wev), .wr_lock(wlk), .wr_lock_val(wlv));
    mrl_mode_regs dut_u (.clk(clk), .rst_n(rst_n), .mode(mode), .reset_src_code(src),
        .nv_restart_limit(nv_rl), .nv_sw_dev(nv_sw), .nv_reset_threshold(nv_thr),
        .nv_programmed(nv_prog), .nv_write_count(nv_cnt), .live_overtemp_warn(lv[4]),
        .live_sw_dev(lv[3]), .live_regulator(lv[2]), .live_can_supply(lv[1]),
        .live_wdog(lv[0]), .spi_active(sa), .spi_commit(sc), .wr_wdog_ctrl(wwc),
        .wr_wdog_mode(wwm), .wr_wdog_period(wwp), .wr_op_mode(1'b0), .wr_op_mode_val(3'h4),
        .wr_threshold(1'b0), .wr_threshold_val(2'h0), .wr_event_en(wen),
        .wr_event_en_val(wev), .wr_lock(wlk), .wr_lock_val(wlv), .wr_evt_clr(wec),
        .wr_evt_clr_val(wcv), .set_overtemp_warn(set_ow), .set_serial_fail(set_sf),
        .set_wdog_fail(set_wf), .set_regulator_uv(set_uv), .op_mode_select(opsel),
        .normal_never_entered(nne), .wdog_period_sel(per), .reset_cause(cause),
        .wdog_mode_sel(wm), .powerup_event(pe), .system_event_summary(sys),
        .supply_event_summary(sup), .transceiver_event_summary(trx),
        .overtemp_warn_state(st[4]), .sw_dev_state(st[3]), .regulator_state(st[2]),
        .can_supply_state(st[1]), .wdog_state(st[0]), .overtemp_warn_event(ow),
        .overtemp_warn_event_en(owe), .serial_fail_event(sfe), .serial_fail_event_en(sfen),
        .wdog_fail_event(wf), .regulator_undervolt_event(uv), .regulator_undervolt_event_en(uve),
        .lock_ctrl_bits(lock), .restart_limit_cfg(rl), .sw_dev_cfg(sw),
        .startup_reset_threshold_cfg(sthr), .reset_threshold_ctrl(thr),
        .nvm_programmed_state(prog), .nvm_write_count(cnt), .device_identity(ident),
        .spi_discard(disc));

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Single value comparison
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Mode change and settle
    task automatic go(input mrl_mode_t m);
        mode = m;
        repeat (3) @(negedge clk);
    endtask
    // Verdict and stop
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (400) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    // Main sequence
    initial begin
        {rst_n, nv_rl, nv_sw, nv_prog, set_sf, src, lv, nv_thr, nv_cnt} = 23'h29FFA5;
        {set_ow, set_wf, set_uv} = 3'h0;
        mode = MRL_OFF;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("opsel", 8'h04, opsel);
        check("nne", 8'h01, nne);
        check("period", 8'h04, per);
        check("cause", 8'h00, cause);
        check("wmode", 8'h02, wm);
        check("powerup", 8'h01, pe);
        check("summary", 8'h04, {sys, sup, trx});
        check("live", 8'h00, st);
        check("events", 8'h00, {sfe, lock});
        check("evtinit", 8'h00, {ow, wf, uv, owe, sfen, uve});
        check("cfg", 8'h0A, {rl, sw, sthr});
        check("thr", 8'h02, thr);
        check("nvstat", 8'h65, {prog, cnt});
        check("ident", 8'h5A, ident);
        go(MRL_STANDBY);
        host_u.write_wdog(3'h1, 4'h9);
        set_sf = 1'b1;
        go(MRL_NORMAL);
        set_sf = 1'b0;
        check("opsel", 8'h0E, {opsel, nne});
        check("keep", 8'h91, {per, cause[3:0]} ^ {4'h0, wm});
        check("live", 8'h1F, st);
        go(MRL_OVERTEMP);
        check("ot", 8'h41, {per, 4'h0} | {7'h00, wm[0]});
        check("cause", 8'h12, cause);
        check("sticky", 8'h06, {nne, sfe, thr});
        src = 5'h0B;
        go(MRL_RESET);
        check("reset", 8'h42, {per, 1'b0, wm});
        check("cause", 8'h0B, cause);
        fork
            host_u.write_wdog(3'h1, 4'hC);
            begin
                repeat (2) @(negedge clk);
                mode = MRL_STANDBY;
                #10 check("spi_discard", 8'h01, disc);
            end
        join
        @(negedge clk);
        check("discard", 8'h44, {per, 1'b0, opsel});
        host_u.write_wdog(3'h1, 4'hC);
        @(negedge clk);
        check("write", 8'h0C, per);
        nv_sw = 1'b1;
        src = 5'h03;
        go(MRL_RESET);
        check("swdev", 8'h19, {cause, wm} ^ {7'h00, 1'b0});
        check("swcfg", 8'h01, sw);
        {set_ow, set_wf, set_uv} = 3'h7;
        @(negedge clk);
        {set_ow, set_wf, set_uv} = 3'h0;
        host_u.write_misc(5'h12, 3'h5, 7'h2A);
        @(negedge clk);
        check("evtclr", 8'h1D, {pe, uv, ow, sfe, wf});
        check("enables", 8'h05, {uve, owe, sfen});
        check("lock", 8'h2A, {1'b0, lock});
        set_sf = 1'b1;
        host_u.write_misc(5'h0F, 3'h2, 7'h55);
        set_sf = 1'b0;
        check("setwins", 8'h12, {pe, uv, ow, sfe, wf});
        go(MRL_OVERTEMP);
        check("modekeep", 8'h12, {pe, uv, ow, sfe, wf});
        check("enkeep", 8'h02, {uve, owe, sfen});
        check("lockkeep", 8'h55, {1'b0, lock});
        end_of_test();
    end
endmodule // tb
